// File: hdl/spz_serial_port_zero.sv
`timescale 1ns/1ps
module spz_serial_port_zero
    import spz_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic baud_tick,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    input wire logic serial_frame_mode_select,
    input wire logic receive_enable_bit,
    input wire logic multiprocessor_check_enable,
    input wire logic irq_enable,
    input wire logic buf_wr,
    input wire logic [SPZ_DATA_BITS-1:0] buf_wdata,
    output logic buf_wr_ready,
    input wire logic tx_done_clr,
    input wire logic rx_done_clr,
    output logic [SPZ_DATA_BITS-1:0] serial_buffer,
    output logic received_ninth_bit,
    output logic transmit_done_flag,
    output logic receive_done_flag,
    output logic tx_busy,
    output logic rx_overrun,
    output logic irq
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic rx_s1_q;
    logic rx_s2_q;
    logic tx_pin_q;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_s1_q <= SPZ_LINE_IDLE;
            rx_s2_q <= SPZ_LINE_IDLE;
        end else begin
            rx_s1_q <= serial_in_pin;
            rx_s2_q <= rx_s1_q;
        end
    end

    // 9-bit mode is not built; transmit is held off while it is selected
    wire mode8 = (serial_frame_mode_select == 1'b0);

    // ************************************************************
    // transmit queue
    // ************************************************************
    spz_stream_if #(.WIDTH(SPZ_DATA_BITS)) q_in ();
    spz_stream_if #(.WIDTH(SPZ_DATA_BITS)) q_out ();
    assign q_in.data = buf_wdata;
    assign q_in.valid = buf_wr;

    spz_fifo #(
        .WIDTH(SPZ_DATA_BITS),
        .DEPTH(SPZ_FIFO_DEPTH)
    ) u_txq (
        .clk(clk),
        .rst_b(rst_b),
        .wr(q_in),
        .rd(q_out)
    );

    // ************************************************************
    // transmitter
    // ************************************************************
    typedef enum logic [1:0] {
        SPZ_TX_IDLE = 2'b00,
        SPZ_TX_START = 2'b01,
        SPZ_TX_DATA = 2'b10,
        SPZ_TX_STOP = 2'b11
    } spz_tx_e;
    spz_tx_e tx_st_q;
    logic [3:0] tx_os_q;
    logic [3:0] tx_bit_q;
    logic [SPZ_DATA_BITS-1:0] tx_sh_q;
    logic tx_stop_edge_q;
    logic tx_busy_q;
    logic ready_q;
    wire tx_bit_end = baud_tick && (tx_os_q == 4'(SPZ_OVERSAMPLE - 1));
    wire tx_last = (tx_bit_q == 4'(SPZ_DATA_BITS - 1));
    wire tx_load = (tx_st_q == SPZ_TX_IDLE) && q_out.valid && mode8;
    assign q_out.ready = tx_load;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_st_q <= SPZ_TX_IDLE;
            tx_os_q <= '0;
            tx_bit_q <= '0;
            tx_sh_q <= SPZ_BUF_RESET;
            tx_pin_q <= SPZ_LINE_IDLE;
            tx_stop_edge_q <= 1'b0;
        end else begin
            tx_stop_edge_q <= 1'b0;
            if (baud_tick) begin
                tx_os_q <= (tx_os_q == 4'(SPZ_OVERSAMPLE - 1)) ? '0 : tx_os_q + 1'b1;
            end
            case (tx_st_q)
                SPZ_TX_IDLE: begin
                    tx_pin_q <= SPZ_LINE_IDLE;
                    tx_os_q <= '0;
                    tx_bit_q <= '0;
                    if (tx_load) begin
                        tx_sh_q <= q_out.data;
                        tx_pin_q <= SPZ_START_LVL;
                        tx_st_q <= SPZ_TX_START;
                    end
                end
                SPZ_TX_START: begin
                    if (tx_bit_end) begin
                        tx_pin_q <= tx_sh_q[0];
                        tx_st_q <= SPZ_TX_DATA;
                    end
                end
                SPZ_TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_bit_q <= tx_bit_q + 1'b1;
                        tx_sh_q <= {1'b0, tx_sh_q[SPZ_DATA_BITS-1:1]};
                        if (tx_last) begin
                            tx_pin_q <= SPZ_STOP_LVL;
                            tx_stop_edge_q <= 1'b1;
                            tx_st_q <= SPZ_TX_STOP;
                        end else begin
                            tx_pin_q <= tx_sh_q[1];
                        end
                    end
                end
                SPZ_TX_STOP: begin
                    if (tx_bit_end) begin
                        tx_st_q <= SPZ_TX_IDLE;
                    end
                end
                default: begin
                    tx_st_q <= SPZ_TX_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    logic rx_done;
    logic [SPZ_DATA_BITS-1:0] rx_data;
    logic rx_stop;
    spz_bit_rx u_rx (
        .clk(clk),
        .rst_b(rst_b),
        .tick(baud_tick),
        .line(rx_s2_q),
        .enable(receive_enable_bit),
        .frame_done(rx_done),
        .frame_data(rx_data),
        .frame_stop(rx_stop)
    );

    // ************************************************************
    // acceptance and flags
    // ************************************************************
    logic [SPZ_DATA_BITS-1:0] buf_q;
    logic ninth_q;
    logic tdone_q;
    logic rdone_q;
    logic ovr_q;
    logic irq_q;
    wire stop_ok = !multiprocessor_check_enable || (rx_stop == SPZ_STOP_LVL);
    wire accept = rx_done && !rdone_q && stop_ok && mode8;
    wire overrun = rx_done && rdone_q;
    wire tdone_d = tx_stop_edge_q || (tdone_q && !tx_done_clr);
    wire rdone_d = accept || (rdone_q && !rx_done_clr);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            buf_q <= SPZ_BUF_RESET;
            ninth_q <= 1'b0;
        end else if (accept) begin
            buf_q <= rx_data;
            ninth_q <= rx_stop;
        end
        // refused frames leave buffer and ninth bit alone
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tdone_q <= 1'b0;
            rdone_q <= 1'b0;
            ovr_q <= 1'b0;
            irq_q <= 1'b0;
            tx_busy_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            // set wins over a clear in the same cycle
            tdone_q <= tdone_d;
            rdone_q <= rdone_d;
            ovr_q <= overrun || (ovr_q && !rx_done_clr);
            irq_q <= irq_enable && (tdone_d || rdone_d);
            tx_busy_q <= (tx_st_q != SPZ_TX_IDLE) || q_out.valid;
            ready_q <= q_in.ready;
        end
    end

    assign serial_out_pin = tx_pin_q;
    assign serial_buffer = buf_q;
    assign received_ninth_bit = ninth_q;
    assign transmit_done_flag = tdone_q;
    assign receive_done_flag = rdone_q;
    assign tx_busy = tx_busy_q;
    assign rx_overrun = ovr_q;
    assign irq = irq_q;
    // registered copy lags one cycle; a write on a just-filled queue is dropped
    assign buf_wr_ready = ready_q;
endmodule

// File: hdl/spz_pkg.sv
package spz_pkg;
    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int SPZ_DATA_BITS = 8;
    localparam int SPZ_FRAME_BITS = 10;
    // ************************************************************
    // bit period, sampling and queue depth
    // ************************************************************
    localparam int SPZ_OVERSAMPLE = 16;
    localparam int SPZ_MID_SAMPLE = 7;
    localparam int SPZ_FIFO_DEPTH = 8;
    // ************************************************************
    // control register bit positions, buffer reset value and line levels
    // ************************************************************
    localparam int SPZ_CTL_TX_DONE = 1;
    localparam int SPZ_CTL_RX_NINTH = 2;
    localparam int SPZ_CTL_RX_EN = 4;
    localparam int SPZ_CTL_MODE = 7;
    localparam logic [7:0] SPZ_BUF_RESET = 8'h00;
    localparam logic SPZ_LINE_IDLE = 1'b1;
    localparam logic SPZ_START_LVL = 1'b0;
    localparam logic SPZ_STOP_LVL = 1'b1;
endpackage

// File: hdl/spz_stream_if.sv
`timescale 1ns/1ps
interface spz_stream_if #(
    parameter int WIDTH = 8
);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport dst (input data, input valid, output ready);
endinterface

// File: hdl/spz_fifo.sv
`timescale 1ns/1ps
module spz_fifo
    import spz_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = SPZ_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    spz_stream_if.dst wr,
    spz_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = wr.valid && wr.ready;
    wire pop = rd.valid && rd.ready;
    wire [AW-1:0] wp_inc = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
    wire [AW-1:0] rp_inc = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;

    // full and empty straight from the count
    assign wr.ready = (cnt_q != (AW + 1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem_q[rp_q];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_inc;
            end
            if (pop) begin
                rp_q <= rp_inc;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// File: hdl/spz_bit_rx.sv
`timescale 1ns/1ps
module spz_bit_rx
    import spz_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic line,
    input wire logic enable,
    output logic frame_done,
    output logic [SPZ_DATA_BITS-1:0] frame_data,
    output logic frame_stop
);
    // ************************************************************
    // oversampled frame receiver, line already synchronised
    // ************************************************************
    typedef enum logic [1:0] {
        SPZ_RX_IDLE = 2'b00,
        SPZ_RX_START = 2'b01,
        SPZ_RX_DATA = 2'b10,
        SPZ_RX_STOP = 2'b11
    } spz_rx_e;
    spz_rx_e st_q;
    logic [3:0] os_q;
    logic [3:0] bit_q;
    logic [SPZ_DATA_BITS-1:0] sh_q;
    logic done_q;
    logic stop_q;
    logic armed_q;
    wire mid = tick && (os_q == 4'(SPZ_MID_SAMPLE));
    wire last_bit = (bit_q == 4'(SPZ_DATA_BITS - 1));

    assign frame_done = done_q;
    assign frame_data = sh_q;
    assign frame_stop = stop_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_q <= SPZ_RX_IDLE;
            os_q <= '0;
            bit_q <= '0;
            sh_q <= SPZ_BUF_RESET;
            done_q <= 1'b0;
            stop_q <= SPZ_STOP_LVL;
            armed_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (tick) begin
                os_q <= (os_q == 4'(SPZ_OVERSAMPLE - 1)) ? '0 : os_q + 1'b1;
            end
            case (st_q)
                SPZ_RX_IDLE: begin
                    os_q <= '0;
                    bit_q <= '0;
                    // a zero stop bit must give way to idle line before a new start
                    if (line == SPZ_LINE_IDLE) begin
                        armed_q <= 1'b1;
                    end
                    // frames only begin while enabled
                    if (enable && armed_q && line == SPZ_START_LVL) begin
                        armed_q <= 1'b0;
                        st_q <= SPZ_RX_START;
                    end
                end
                SPZ_RX_START: begin
                    if (mid) begin
                        // glitch shorter than half a bit is dropped
                        st_q <= (line == SPZ_START_LVL) ? SPZ_RX_DATA : SPZ_RX_IDLE;
                    end
                end
                SPZ_RX_DATA: begin
                    if (mid) begin
                        sh_q <= {line, sh_q[SPZ_DATA_BITS-1:1]};
                        bit_q <= bit_q + 1'b1;
                        if (last_bit) begin
                            st_q <= SPZ_RX_STOP;
                        end
                    end
                end
                SPZ_RX_STOP: begin
                    if (mid) begin
                        stop_q <= line;
                        done_q <= 1'b1;
                        st_q <= SPZ_RX_IDLE;
                    end
                end
                default: begin
                    st_q <= SPZ_RX_IDLE;
                end
            endcase
        end
    end
endmodule

// File: tb/spz_remote_model.sv
`timescale 1ns/1ps
// ************************************************************
// remote serial party
// ************************************************************
module spz_remote_model (
    input wire logic clk,
    input wire logic baud_tick,
    input wire logic rx_line,
    output logic tx_line
);
    logic [7:0] got_q[$];
    logic [7:0] shf;
    initial tx_line = 1'b1;
    task automatic ticks(input int n);
        repeat (n) @(posedge clk iff baud_tick);
    endtask
    // start, data lsb first, stop; stop level chosen by caller
    task automatic send(input logic [7:0] b, input logic stop_bit);
        logic [9:0] fr;
        fr = {stop_bit, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            tx_line <= fr[i];
            ticks(16);
        end
        tx_line <= 1'b1;
    endtask
    // mid-bit sampling, no check of stop level
    initial begin
        forever begin
            @(posedge clk iff rx_line === 1'b0);
            ticks(8);
            for (int i = 0; i < 8; i++) begin
                ticks(16);
                shf[i] = rx_line;
            end
            ticks(16);
            got_q.push_back(shf);
        end
    end
endmodule

// File: tb/spz_port_assertions.sv
`timescale 1ns/1ps
module spz_port_assertions
    import spz_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic buf_wr,
    input wire logic serial_frame_mode_select,
    input wire logic irq_enable,
    input wire logic tx_done_clr,
    input wire logic rx_done_clr,
    input logic serial_out_pin,
    input logic buf_wr_ready,
    input logic [SPZ_DATA_BITS-1:0] serial_buffer,
    input logic received_ninth_bit,
    input logic transmit_done_flag,
    input logic receive_done_flag,
    input logic tx_busy,
    input logic rx_overrun,
    input logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ************************************************************
    // properties
    // ************************************************************
    sequence s_start_bit;
        ##2 !serial_out_pin ##1 !serial_out_pin;
    endsequence
    property p_start;
        buf_wr && buf_wr_ready && !tx_busy && !serial_frame_mode_select |-> s_start_bit;
    endproperty
    property p_idle;
        !tx_busy |-> serial_out_pin;
    endproperty
    property p_tx_done;
        $rose(transmit_done_flag) |-> serial_out_pin && tx_busy;
    endproperty
    property p_tx_sticky;
        transmit_done_flag && !tx_done_clr |=> transmit_done_flag;
    endproperty
    property p_rx_sticky;
        receive_done_flag && !rx_done_clr |=> receive_done_flag;
    endproperty
    property p_buf_hold;
        receive_done_flag && !rx_done_clr |=> $stable(serial_buffer) && $stable(received_ninth_bit);
    endproperty
    property p_buf_load;
        !$stable(serial_buffer) || !$stable(received_ninth_bit) |-> $rose(receive_done_flag);
    endproperty
    property p_irq;
        irq == ($past(irq_enable) && (transmit_done_flag || receive_done_flag));
    endproperty
    property p_overrun;
        $rose(rx_overrun) |-> receive_done_flag && $stable(serial_buffer);
    endproperty
    // ************************************************************
    // assertions
    // ************************************************************
    a_start: assert property (p_start) else $error("no start bit after write");
    a_idle: assert property (p_idle) else $error("line low while idle");
    a_tx_done: assert property (p_tx_done) else $error("tx done off stop bit");
    a_tx_sticky: assert property (p_tx_sticky) else $error("tx done dropped");
    a_rx_sticky: assert property (p_rx_sticky) else $error("rx done dropped");
    a_buf_hold: assert property (p_buf_hold) else $error("buffer moved while full");
    a_buf_load: assert property (p_buf_load) else $error("buffer moved without done");
    a_irq: assert property (p_irq) else $error("irq mismatch");
    a_overrun: assert property (p_overrun) else $error("overrun lost byte");
endmodule
bind spz_serial_port_zero spz_port_assertions u_chk (.clk(clk), .rst_b(rst_b), .buf_wr(buf_wr),
    .serial_frame_mode_select(serial_frame_mode_select), .irq_enable(irq_enable),
    .tx_done_clr(tx_done_clr), .rx_done_clr(rx_done_clr), .serial_out_pin(serial_out_pin),
    .buf_wr_ready(buf_wr_ready), .serial_buffer(serial_buffer),
    .received_ninth_bit(received_ninth_bit), .transmit_done_flag(transmit_done_flag),
    .receive_done_flag(receive_done_flag), .tx_busy(tx_busy), .rx_overrun(rx_overrun),
    .irq(irq));

// File: tb/spz_serial_port_zero_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, a, e); end end
module spz_serial_port_zero_test;
    import spz_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, baud_tick = 1'b0, sin, sout, mode = 1'b0, ren = 1'b0;
    logic mce = 1'b0, irq_en = 1'b1, buf_wr = 1'b0, tx_clr = 1'b0, rx_clr = 1'b0;
    logic [7:0] wdata = 8'h00, sbuf;
    logic [7:0] got_b;
    logic wr_rdy, ninth, tx_done, rx_done, busy, ovr, irq;
    int error_cnt = 0, total_checks = 0;
    always #5 clk = ~clk;
    // tick every other cycle keeps frames short
    always @(posedge clk) baud_tick <= ~baud_tick;
    spz_serial_port_zero DUT (.clk(clk), .rst_b(rst_b), .baud_tick(baud_tick),
        .serial_in_pin(sin), .serial_out_pin(sout), .serial_frame_mode_select(mode),
        .receive_enable_bit(ren), .multiprocessor_check_enable(mce), .irq_enable(irq_en),
        .buf_wr(buf_wr), .buf_wdata(wdata), .buf_wr_ready(wr_rdy), .tx_done_clr(tx_clr),
        .rx_done_clr(rx_clr), .serial_buffer(sbuf), .received_ninth_bit(ninth),
        .transmit_done_flag(tx_done), .receive_done_flag(rx_done), .tx_busy(busy),
        .rx_overrun(ovr), .irq(irq));
    spz_remote_model u_remote (.clk(clk), .baud_tick(baud_tick), .rx_line(sout), .tx_line(sin));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic write_byte(input logic [7:0] b);
        @(posedge clk);
        buf_wr <= 1'b1;
        wdata <= b;
        @(posedge clk);
        buf_wr <= 1'b0;
    endtask
    task automatic clear_flags(input logic t, input logic r);
        @(posedge clk);
        tx_clr <= t;
        rx_clr <= r;
        @(posedge clk);
        tx_clr <= 1'b0;
        rx_clr <= 1'b0;
        #1;
    endtask
    task automatic wait_sent(input int n);
        for (int i = 0; i < 5000 && u_remote.got_q.size() < n; i++) @(posedge clk);
        // a frame that never arrives counts as a mismatch
        if (u_remote.got_q.size() < n) error_cnt++;
        #1;
    endtask
    task automatic rx_frame(input logic [7:0] b, input logic s);
        u_remote.send(b, s);
        repeat (4) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        `CHK(sout, 1'b1)
        `CHK({tx_done, rx_done, ovr, irq, sbuf}, 12'h000)
        // nine back to back writes: one loads at once, eight fill the queue
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            buf_wr <= 1'b1;
            wdata <= 8'(i * 29 + 5);
        end
        @(posedge clk);
        buf_wr <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(wr_rdy, 1'b0)
        wait_sent(9);
        for (int i = 0; i < 9; i++) begin
            got_b = u_remote.got_q.pop_front();
            `CHK(got_b, 8'(i * 29 + 5))
        end
        `CHK(tx_done, 1'b1)
        `CHK(irq, 1'b1)
        clear_flags(1'b1, 1'b0);
        `CHK(tx_done, 1'b0)
        rx_frame(8'h81, 1'b1);
        `CHK(rx_done, 1'b0)
        ren <= 1'b1;
        rx_frame(8'h5A, 1'b1);
        `CHK({rx_done, ninth, sbuf}, 10'h35A)
        `CHK(irq, 1'b1)
        @(posedge clk);
        irq_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        `CHK({irq, rx_done}, 2'h1)
        irq_en <= 1'b1;
        rx_frame(8'hC3, 1'b1);
        `CHK({ovr, rx_done, sbuf}, 10'h35A)
        clear_flags(1'b0, 1'b1);
        `CHK({ovr, rx_done, irq}, 3'h0)
        // 9-bit select: transmit stalls in the queue, received frame refused
        mode <= 1'b1;
        fork
            rx_frame(8'h24, 1'b1);
            write_byte(8'hA5);
        join
        `CHK({busy, sout, rx_done, sbuf}, 11'h65A)
        mode <= 1'b0;
        wait_sent(1);
        got_b = u_remote.got_q.pop_front();
        `CHK(got_b, 8'hA5)
        mce <= 1'b1;
        rx_frame(8'h3E, 1'b0);
        `CHK({rx_done, ninth, sbuf}, 10'h15A)
        mce <= 1'b0;
        fork
            rx_frame(8'h96, 1'b0);
            write_byte(8'h69);
        join
        wait_sent(1);
        `CHK({rx_done, ninth, sbuf}, 10'h296)
        got_b = u_remote.got_q.pop_front();
        `CHK(got_b, 8'h69)
        repeat (40) @(posedge clk);
        #1;
        `CHK({busy, sout, wr_rdy}, 3'h3)
        report_and_stop();
    end
endmodule
